// >>> rtl/usc_consts.svh
// Register map, field positions, reset values and timing counts.
// How it works
// RQ1 - FIFO enable turns both FIFOs on; clearing it empties both.
// RQ2 - Host writes FIFO enable as one with any other FIFO control bit.
// RQ3 - Receive flush empties receive FIFO, keeps shift register, self-clears.
// RQ4 - Transmit flush empties transmit FIFO, keeps shifter, self-clears.
// RQ5 - DMA select bit is accepted but has no effect; no DMA pins.
// RQ6 - Reserved FIFO control and modem control bits ignore writes, read zero.
// RQ7 - Receive trigger field selects 1, 4, 8 or 14 bytes.
// RQ8 - Word length field selects five to eight data bits.
// RQ9 - Stop bit sets two stop bits, or one and a half for five bits.
// RQ10 - Receiver checks only the first stop bit.
// RQ11 - Parity bit sits after the last data bit, before the stop bit.
// RQ12 - Parity polarity zero gives odd ones, one gives even ones.
// RQ13 - Fixed parity sends and expects the inverse of parity polarity.
// RQ14 - Break bit holds the transmit pin at zero until cleared.
// RQ15 - Divisor access bit routes low offsets to the divisor latches.
// RQ16 - Terminal ready, request to send drive inverted pins; aux one pinless.
// RQ17 - Aux two enables the interrupt output driver.
// RQ18 - Loopback: pin marks, inputs ignored, data looped, outputs inactive.
// RQ19 - Loopback feeds modem control bits into modem status.
// RQ20 - Receive and transmit interrupts work unchanged in loopback.
// RQ21 - Data ready sets on a stored character, clears when all read.
// RQ22 - Overrun flags replaced or dropped character; line status read clears.
// RQ23 - Parity error travels with its character, reported at FIFO head.
// RQ24 - FIFO indication bits read one while FIFOs are enabled.
// RQ25 - Overrun, parity, framing and break raise the line status interrupt; the code has no break detect, so only the other three do.
// RQ26 - Receiver finds bit centres by counting sixteen ticks per bit.
`ifndef USC_CONSTS_SVH
`define USC_CONSTS_SVH

`define USC_IDX_DATA 3'h0
`define USC_IDX_IER 3'h1
`define USC_IDX_FIFO 3'h2
`define USC_IDX_LFC 3'h3
`define USC_IDX_MLC 3'h4
`define USC_IDX_LST 3'h5
`define USC_IDX_MST 3'h6
`define USC_IDX_SCR 3'h7

`define USC_FC_ENABLE 0
`define USC_FC_RX_FLUSH 1
`define USC_FC_TX_FLUSH 2
`define USC_FC_TRIG 7:6

`define USC_LF_WLEN 1:0
`define USC_LF_STOP 2
`define USC_LF_PEN 3
`define USC_LF_EPS 4
`define USC_LF_STICK 5
`define USC_LF_BREAK 6
`define USC_LF_DIVISOR_ACCESS_BIT 7

`define USC_ML_DTR 0
`define USC_ML_RTS 1
`define USC_ML_AUX_OUTPUT_ONE 2
`define USC_ML_AUX_OUTPUT_TWO_IRQ_ENABLE 3
`define USC_ML_LOOP 4

`define USC_RST_LFC 8'h00
`define USC_RST_MLC 5'h00
`define USC_RST_IER 4'h0
`define USC_RST_TRIG 2'h0

`define USC_TRIG_1 5'h01
`define USC_TRIG_4 5'h04
`define USC_TRIG_8 5'h08
`define USC_TRIG_14 5'h0e

`define USC_FIFO_DEPTH 16
`define USC_TICK_LAST 6'h0f
`define USC_TICK_HALF 6'h07
`define USC_STOP1_LAST 6'h0f
`define USC_STOP15_LAST 6'h17
`define USC_STOP2_LAST 6'h1f

`endif

// >>> rtl/usc_pkg.sv
// Types shared by the serial port control logic.
package usc_pkg;
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_START = 5'h02,
		ST_DATA = 5'h04,
		ST_PAR = 5'h08,
		ST_STOP = 5'h10
	} usc_ser_state_t;
endpackage

// >>> rtl/usc_uart.sv
// Serial port with FIFOs, line format, modem control and line status.
//
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "usc_consts.svh"
module usc_uart
	import usc_pkg::*;
#(
	parameter int DEPTH = `USC_FIFO_DEPTH
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [2:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic rxd_in,
	output logic txd_out,
	input wire logic clear_to_send_in_n,
	input wire logic data_set_ready_in_n,
	input wire logic ring_in_n,
	input wire logic carrier_detect_in_n,
	output logic terminal_ready_out_n,
	output logic request_to_send_out_n,
	output logic irq_out,
	output logic irq_oe
);
	localparam int AW = $clog2(DEPTH);

	function automatic logic usc_parity(input logic [7:0] d,
		input logic [7:0] fmt);
		logic [7:0] m;
		m = d & (8'hff >> (2'h3 - fmt[`USC_LF_WLEN]));
		if (fmt[`USC_LF_STICK])
			usc_parity = ~fmt[`USC_LF_EPS];
		else
			usc_parity = fmt[`USC_LF_EPS] ? ^m : ~^m;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Register state and bus decode.

	logic ack;
	logic [7:0] line_format_control;
	logic [4:0] modem_line_control;
	logic [3:0] ier;
	logic [7:0] scr, div_lo, div_hi;
	logic fifo_en;
	logic [1:0] rx_trig_sel;
	logic oe_f, pe_f, fe_f, thre_f, thre_q;
	logic [3:0] ms_delta, ms_q;
	logic [7:0] next_rdata;

	wire acc = (avs_read | avs_write) & ack;
	wire wr_en = acc & avs_write & avs_byteenable[0];
	wire rd_en = acc & avs_read;
	wire divisor_access_bit = line_format_control[`USC_LF_DIVISOR_ACCESS_BIT];
	wire loop = modem_line_control[`USC_ML_LOOP];
	wire sel_data = avs_address == `USC_IDX_DATA;
	wire sel_ier = avs_address == `USC_IDX_IER;
	wire sel_fifo = avs_address == `USC_IDX_FIFO;
	wire sel_lfc = avs_address == `USC_IDX_LFC;
	wire sel_mlc = avs_address == `USC_IDX_MLC;
	wire sel_lst = avs_address == `USC_IDX_LST;
	wire sel_mst = avs_address == `USC_IDX_MST;
	wire [7:0] wd = avs_writedata[7:0];
	wire fifo_wr = wr_en & sel_fifo;
	// Other FIFO control bits only act when written along with enable. [RQ2]
	wire fifo_wr_on = fifo_wr & wd[`USC_FC_ENABLE];
	wire fifo_off = fifo_wr & ~wd[`USC_FC_ENABLE];  // [RQ1]
	wire rx_flush = fifo_off | (fifo_wr_on & wd[`USC_FC_RX_FLUSH]);  // [RQ3]
	wire tx_flush = fifo_off | (fifo_wr_on & wd[`USC_FC_TX_FLUSH]);  // [RQ4]
	wire thr_wr = wr_en & sel_data & ~divisor_access_bit;  // [RQ15]
	wire rbr_rd = rd_en & sel_data & ~divisor_access_bit;  // [RQ15]

	// One wait cycle on every access keeps read data in a flip-flop.
	assign avs_waitrequest = (avs_read | avs_write) & ~ack;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers: a level counts once stages two and three agree.

	logic [4:0] pin_s1, pin_s2, pin_s3, pin_f;
	wire [4:0] pin_raw = {rxd_in, carrier_detect_in_n, ring_in_n,
		data_set_ready_in_n, clear_to_send_in_n};
	wire [4:0] pin_agree = ~(pin_s2 ^ pin_s3);

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pin_s1 <= 5'h1f;
			pin_s2 <= 5'h1f;
			pin_s3 <= 5'h1f;
			pin_f <= 5'h1f;
		end else begin
			pin_s1 <= pin_raw;
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			pin_f <= (pin_f & ~pin_agree) | (pin_s3 & pin_agree);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Transmit FIFO; in single-byte mode its capacity is one.

	logic [7:0] tx_mem [DEPTH];
	logic [AW-1:0] tx_wp, tx_rp;
	logic [AW:0] tx_count;
	logic tx_load;
	wire [AW:0] cap = fifo_en ? (AW+1)'(DEPTH) : (AW+1)'(1);
	wire tx_push = thr_wr & (tx_count < cap);

	always_ff @(posedge clk_sys) begin
		if (tx_push)
			tx_mem[tx_wp] <= wd;
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			tx_wp <= '0;
			tx_rp <= '0;
			tx_count <= '0;
		end else if (tx_flush) begin
			tx_wp <= '0;
			tx_rp <= '0;
			tx_count <= '0;
		end else begin
			tx_wp <= tx_wp + AW'(tx_push);
			tx_rp <= tx_rp + AW'(tx_load);
			tx_count <= tx_count + (AW+1)'(tx_push) - (AW+1)'(tx_load);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Transmitter; the shift register survives a FIFO flush.

	usc_ser_state_t tx_st;
	logic [5:0] tx_tick;
	logic [2:0] tx_bit;
	logic [7:0] tx_sh;
	logic tx_line, tx_par;
	wire [2:0] wlast = 3'h4 + {1'b0, line_format_control[`USC_LF_WLEN]};  // [RQ8]
	wire pen = line_format_control[`USC_LF_PEN];
	wire tx_end = tx_tick == `USC_TICK_LAST;
	// Two stop bits, or one and a half with five-bit words. [RQ9]
	wire [5:0] stop_last = ~line_format_control[`USC_LF_STOP] ?
		`USC_STOP1_LAST : (wlast == 3'h4) ? `USC_STOP15_LAST :
		`USC_STOP2_LAST;
	// Break overrides the transmitter, also on the looped path. [RQ14]
	wire tx_ser = ~line_format_control[`USC_LF_BREAK] & tx_line;

	assign tx_load = (tx_st == ST_IDLE) & (tx_count != '0) & ~tx_flush;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			tx_st <= ST_IDLE;
			tx_tick <= '0;
			tx_bit <= '0;
			tx_sh <= '0;
			tx_line <= 1'b1;
			tx_par <= 1'b0;
		end else begin
			tx_tick <= tx_tick + 6'h01;
			unique case (tx_st)
			ST_IDLE: begin
				tx_tick <= '0;
				if (tx_load) begin
					tx_sh <= tx_mem[tx_rp];
					tx_par <= usc_parity(tx_mem[tx_rp], line_format_control);
					tx_line <= 1'b0;
					tx_st <= ST_START;
				end
			end
			ST_START: if (tx_end) begin
				tx_tick <= '0;
				tx_bit <= '0;
				tx_line <= tx_sh[0];
				tx_st <= ST_DATA;
			end
			ST_DATA: if (tx_end) begin
				tx_tick <= '0;
				if (tx_bit == wlast) begin
					// Parity goes between last data bit and stop. [RQ11]
					tx_line <= pen ? tx_par : 1'b1;
					tx_st <= pen ? ST_PAR : ST_STOP;
				end else begin
					tx_line <= tx_sh[1];
					tx_sh <= tx_sh >> 1;
					tx_bit <= tx_bit + 3'h1;
				end
			end
			ST_PAR: if (tx_end) begin
				tx_tick <= '0;
				tx_line <= 1'b1;
				tx_st <= ST_STOP;
			end
			ST_STOP: if (tx_tick == stop_last) begin
				tx_tick <= '0;
				tx_st <= ST_IDLE;
			end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Receiver on the 16x clock, centre of each bit found by counting.

	usc_ser_state_t rx_st;
	logic [5:0] rx_tick;
	logic [2:0] rx_bit;
	logic [7:0] rx_data;
	logic rx_perr, rx_done;
	logic [9:0] rx_word;
	wire rx_line = loop ? tx_ser : pin_f[4];  // [RQ18]
	wire rx_mid = rx_tick == `USC_TICK_LAST;  // [RQ26]

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rx_st <= ST_IDLE;
			rx_tick <= '0;
			rx_bit <= '0;
			rx_data <= '0;
			rx_perr <= 1'b0;
			rx_done <= 1'b0;
			rx_word <= '0;
		end else begin
			rx_done <= 1'b0;
			rx_tick <= rx_tick + 6'h01;
			unique case (rx_st)
			ST_IDLE: begin
				rx_tick <= '0;
				if (~rx_line)
					rx_st <= ST_START;
			end
			ST_START: if (rx_tick == `USC_TICK_HALF) begin
				// A glitch shorter than half a bit is not a start.
				rx_tick <= '0;
				rx_bit <= '0;
				rx_data <= '0;
				rx_perr <= 1'b0;
				rx_st <= rx_line ? ST_IDLE : ST_DATA;
			end
			ST_DATA: if (rx_mid) begin  // [RQ26]
				rx_tick <= '0;
				rx_data[rx_bit] <= rx_line;
				rx_bit <= rx_bit + 3'h1;
				if (rx_bit == wlast)
					rx_st <= pen ? ST_PAR : ST_STOP;  // [RQ11]
			end
			ST_PAR: if (rx_mid) begin
				rx_tick <= '0;
				// Same polarity and fixed level as sending. [RQ12] [RQ13]
				rx_perr <= rx_line != usc_parity(rx_data, line_format_control);
				rx_st <= ST_STOP;
			end
			ST_STOP: if (rx_mid) begin
				// Only the first stop bit is looked at. [RQ10]
				rx_tick <= '0;
				rx_done <= 1'b1;
				rx_word <= {~rx_line, rx_perr, rx_data};
				rx_st <= ST_IDLE;
			end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Receive FIFO; each entry carries its own error bits.

	logic [9:0] rx_mem [DEPTH];
	logic [AW-1:0] rx_wp, rx_rp;
	logic [AW:0] rx_count;
	logic head_new;
	wire rx_full = rx_count >= cap;
	wire rx_over = rx_done & rx_full;  // [RQ22]
	wire rx_repl = rx_over & ~fifo_en;  // [RQ22]
	wire rx_push = rx_done & ~rx_full;
	wire rx_pop = rbr_rd & (rx_count != '0) & ~rx_repl;
	wire [9:0] rx_head = rx_mem[rx_rp];

	always_ff @(posedge clk_sys) begin
		if (rx_push | rx_repl)
			rx_mem[rx_repl ? rx_rp : rx_wp] <= rx_word;
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rx_wp <= '0;
			rx_rp <= '0;
			rx_count <= '0;
			head_new <= 1'b0;
		end else if (rx_flush) begin
			rx_wp <= '0;
			rx_rp <= '0;
			rx_count <= '0;
			head_new <= 1'b0;
		end else begin
			rx_wp <= rx_wp + AW'(rx_push);
			rx_rp <= rx_rp + AW'(rx_pop);
			rx_count <= rx_count + (AW+1)'(rx_push) - (AW+1)'(rx_pop);
			head_new <= rx_repl | (rx_pop ? (rx_count > (AW+1)'(1)) | rx_push
				: rx_push & (rx_count == '0));
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Status, modem status and interrupt sources.

	wire dr = rx_count != '0;  // [RQ21]
	wire thre = tx_count == '0;
	wire temt = thre & (tx_st == ST_IDLE);
	wire [7:0] line_status = {1'b0, temt, thre, 1'b0, fe_f, pe_f, oe_f, dr};
	// Loopback feeds modem control bits back as status. [RQ19]
	wire [3:0] ms = loop ? {modem_line_control[`USC_ML_AUX_OUTPUT_TWO_IRQ_ENABLE],
		modem_line_control[`USC_ML_AUX_OUTPUT_ONE], modem_line_control[`USC_ML_DTR],
		modem_line_control[`USC_ML_RTS]} : ~pin_f[3:0];  // [RQ18]
	wire [3:0] ms_set = {ms[3] ^ ms_q[3], ms_q[2] & ~ms[2],
		ms[1] ^ ms_q[1], ms[0] ^ ms_q[0]};
	wire [4:0] rx_trig = rx_trig_sel == 2'h0 ? `USC_TRIG_1 :
		rx_trig_sel == 2'h1 ? `USC_TRIG_4 :
		rx_trig_sel == 2'h2 ? `USC_TRIG_8 : `USC_TRIG_14;  // [RQ7]
	wire rls_p = ier[2] & (oe_f | pe_f | fe_f);  // [RQ25]
	wire rda_p = ier[0] & (fifo_en ? 32'(rx_count) >= 32'(rx_trig) : dr);
	wire thre_p = ier[1] & thre_f;
	wire msi_p = ier[3] & (|ms_delta);
	wire [2:0] iid = rls_p ? 3'h3 : rda_p ? 3'h2 : thre_p ? 3'h1 : 3'h0;
	wire any_p = rls_p | rda_p | thre_p | msi_p;
	wire [7:0] interrupt_identification = {fifo_en, fifo_en, 2'h0, iid, ~any_p};  // [RQ24]
	wire lsr_rd = rd_en & sel_lst;
	wire msr_rd = rd_en & sel_mst;
	wire thre_clr = (rd_en & sel_fifo & avs_readdata[3:0] == 4'h2) | tx_push;

	// Flags clear only in bits the host has seen, except thre_f on a transmit write, and a new event wins.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			oe_f <= 1'b0;
			pe_f <= 1'b0;
			fe_f <= 1'b0;
			thre_f <= 1'b0;
			thre_q <= 1'b1;
			ms_q <= '0;
			ms_delta <= '0;
		end else begin
			oe_f <= rx_over | (oe_f & ~(lsr_rd & avs_readdata[1]));  // [RQ22]
			pe_f <= (head_new & rx_head[8]) |
				(pe_f & ~(lsr_rd & avs_readdata[2]));  // [RQ23]
			fe_f <= (head_new & rx_head[9]) |
				(fe_f & ~(lsr_rd & avs_readdata[3]));
			thre_q <= thre;
			thre_f <= (thre & ~thre_q) | (thre_f & ~thre_clr);  // [RQ20]
			ms_q <= ms;
			ms_delta <= ms_set | (ms_delta & ~({4{msr_rd}} & avs_readdata[3:0]));
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register writes and read data.

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			line_format_control <= `USC_RST_LFC;
			modem_line_control <= `USC_RST_MLC;
			ier <= `USC_RST_IER;
			fifo_en <= 1'b0;
			rx_trig_sel <= `USC_RST_TRIG;
			scr <= '0;
			div_lo <= '0;
			div_hi <= '0;
		end else if (wr_en) begin
			if (sel_data & divisor_access_bit)
				div_lo <= wd;  // [RQ15]
			if (sel_ier & divisor_access_bit)
				div_hi <= wd;  // [RQ15]
			if (sel_ier & ~divisor_access_bit)
				ier <= wd[3:0];
			if (sel_fifo)
				fifo_en <= wd[`USC_FC_ENABLE];  // [RQ1]
			// The DMA select bit is not stored and has no effect. [RQ5]
			if (fifo_wr_on)
				rx_trig_sel <= wd[`USC_FC_TRIG];  // [RQ7]
			if (sel_lfc)
				line_format_control <= wd;
			if (sel_mlc)
				modem_line_control <= wd[4:0];  // [RQ6]
			if (avs_address == `USC_IDX_SCR)
				scr <= wd;
		end
	end

	always_comb begin
		next_rdata = 8'h00;
		unique case (avs_address)
		`USC_IDX_DATA: next_rdata = divisor_access_bit ? div_lo : rx_head[7:0];
		`USC_IDX_IER: next_rdata = divisor_access_bit ? div_hi : {4'h0, ier};
		`USC_IDX_FIFO: next_rdata = interrupt_identification;
		`USC_IDX_LFC: next_rdata = line_format_control;
		`USC_IDX_MLC: next_rdata = {3'h0, modem_line_control};  // [RQ6]
		`USC_IDX_LST: next_rdata = line_status;
		`USC_IDX_MST: next_rdata = {ms, ms_delta};
		`USC_IDX_SCR: next_rdata = scr;
		endcase
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ack <= 1'b0;
			avs_readdata <= '0;
			txd_out <= 1'b1;
			terminal_ready_out_n <= 1'b1;
			request_to_send_out_n <= 1'b1;
			irq_out <= 1'b0;
			irq_oe <= 1'b0;
		end else begin
			ack <= (avs_read | avs_write) & ~ack;
			if (avs_read & ~ack)
				avs_readdata <= {24'h0, next_rdata};
			txd_out <= loop | tx_ser;  // [RQ14] [RQ18]
			terminal_ready_out_n <= loop | ~modem_line_control[`USC_ML_DTR];  // [RQ16]
			request_to_send_out_n <= loop | ~modem_line_control[`USC_ML_RTS];  // [RQ16]
			irq_out <= any_p;
			irq_oe <= modem_line_control[`USC_ML_AUX_OUTPUT_TWO_IRQ_ENABLE];  // [RQ17]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	sequence s_fifo_off;
		fifo_wr & ~wd[`USC_FC_ENABLE];
	endsequence
	sequence s_rx_flush;
		fifo_wr & wd[`USC_FC_ENABLE] & wd[`USC_FC_RX_FLUSH];
	endsequence
	sequence s_tx_flush;
		fifo_wr & wd[`USC_FC_ENABLE] & wd[`USC_FC_TX_FLUSH];
	endsequence

	property p_fifo_off;
		s_fifo_off |=> ~fifo_en && rx_count == '0 && tx_count == '0;
	endproperty
	a_fifo_off: assert property (p_fifo_off) else $error("FIFO off."); // [RQ1]
	property p_rx_flush;
		s_rx_flush |=> rx_count == '0;
	endproperty
	a_rx_flush: assert property (p_rx_flush) else $error("RX flush."); // [RQ3]
	property p_tx_flush;
		s_tx_flush |=> tx_count == '0;
	endproperty
	a_tx_flush: assert property (p_tx_flush) else $error("TX flush."); // [RQ4]
	property p_mlc_rsvd;
		ack & avs_read & sel_mlc |-> avs_readdata[7:5] == 3'h0;
	endproperty
	a_mlc_rsvd: assert property (p_mlc_rsvd) else $error("Reserved."); // [RQ6]
	property p_break;
		line_format_control[`USC_LF_BREAK] & ~loop |=> ~txd_out;
	endproperty
	a_break: assert property (p_break) else $error("Break not held."); // [RQ14]
	property p_loop_pins;
		loop |=> txd_out & terminal_ready_out_n & request_to_send_out_n;
	endproperty
	a_loop_pins: assert property (p_loop_pins) else $error("Pins on."); // [RQ18]
	property p_irq_float;
		~modem_line_control[`USC_ML_AUX_OUTPUT_TWO_IRQ_ENABLE] |=> ~irq_oe;
	endproperty
	a_irq_float: assert property (p_irq_float) else $error("IRQ on."); // [RQ17]
	property p_dr;
		rx_push & ~rx_flush |=> line_status[0];
	endproperty
	a_dr: assert property (p_dr) else $error("Data ready missed."); // [RQ21]
	property p_overrun;
		rx_over |=> oe_f ##1 oe_f | lsr_rd;
	endproperty
	a_overrun: assert property (p_overrun) else $error("Overrun lost."); // [RQ22]
	property p_iir_fifo;
		rd_en & sel_fifo & fifo_en |-> avs_readdata[7:6] == 2'h3;
	endproperty
	a_iir_fifo: assert property (p_iir_fifo) else $error("FIFO bits."); // [RQ24]
	property p_rls_irq;
		rls_p |=> irq_out;
	endproperty
	a_rls_irq: assert property (p_rls_irq) else $error("No RLS irq."); // [RQ25]
endmodule
`default_nettype wire

// >>> bench/usc_line_partner.sv
// Remote serial device: sends framed characters and captures transmit frames.
`timescale 1ns/1ps
`default_nettype none
module usc_line_partner (
	input wire logic clk_sys,
	input wire logic txd_out,
	output logic rxd_in
);
	int nbits = 10;
	logic [11:0] capq[$];
	longint period = 0;
	longint last_fall = 0;
	logic [11:0] cap;

	////////////////////////////////////////////////////////////////////////
	// Sampling on the falling clock edge keeps clear of the registered
	// transmit output changing on the rising edge.
	initial begin
		rxd_in = 1'b1;
		forever begin
			@(negedge clk_sys);
			if (txd_out === 1'b0) begin
				period = $time - last_fall;
				last_fall = $time;
				cap = '1;
				repeat (8) @(negedge clk_sys);
				for (int i = 0; i < nbits; i++) begin
					cap[i] = txd_out;
					if (i < nbits - 1) begin
						repeat (16) @(negedge clk_sys);
					end
				end
				capq.push_back(cap);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Call on a rising edge; one marking clock follows each frame, so two
	// calls in a row never drive the line twice in one time step.
	task automatic send_char(input logic [11:0] f, input int n);
		for (int i = 0; i < n; i++) begin
			rxd_in <= f[i];
			repeat (16) @(posedge clk_sys);
		end
		rxd_in <= 1'b1;
		@(posedge clk_sys);
	endtask
endmodule
`default_nettype wire

// >>> bench/usc_uart_bench.sv
// Self-checking bench for the serial port control logic.
`timescale 1ns/1ps
`default_nettype none
module usc_uart_bench;
	import usc_pkg::*;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic [2:0] avs_address = 3'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0] avs_byteenable = 4'h1;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic rxd_in;
	logic txd_out;
	logic [3:0] modem_n = 4'hf;
	logic terminal_ready_out_n;
	logic request_to_send_out_n;
	logic irq_out;
	logic irq_oe;
	logic [7:0] pins;
	int n_errors = 0;
	int n_tests = 0;
	int cycles = 0;
	logic [31:0] seed = 32'he1d74f3f;
	logic [31:0] r;
	logic [7:0] q, lf, d1, d2;
	logic bad;

	assign pins = {4'h0, txd_out, terminal_ready_out_n,
		request_to_send_out_n, irq_oe};

	usc_uart usc_uart_inst (.clk_sys(clk_sys), .rst(rst),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .rxd_in(rxd_in),
		.txd_out(txd_out), .clear_to_send_in_n(modem_n[0]),
		.data_set_ready_in_n(modem_n[1]), .ring_in_n(modem_n[2]),
		.carrier_detect_in_n(modem_n[3]),
		.terminal_ready_out_n(terminal_ready_out_n),
		.request_to_send_out_n(request_to_send_out_n),
		.irq_out(irq_out), .irq_oe(irq_oe));

	usc_line_partner usc_line_partner_inst (.clk_sys(clk_sys),
		.txd_out(txd_out), .rxd_in(rxd_in));

	initial begin
		forever #50 clk_sys = ~clk_sys;
	end

	////////////////////////////////////////////////////////////////////////
	function automatic logic [11:0] mk_frame(input logic [7:0] d,
		input logic [7:0] f, input logic e);
		logic [11:0] fr;
		logic p;
		fr = '1;
		fr[0] = 1'b0;
		p = 1'b0;
		for (int i = 0; i < 5 + f[1:0]; i++) begin
			fr[i + 1] = d[i];
			p = p ^ d[i];
		end
		p = f[5] ? ~f[4] : p ^ ~f[4];
		if (f[3]) begin
			fr[6 + f[1:0]] = p ^ e;
		end
		return fr;
	endfunction

	function automatic int n_bits(input logic [7:0] f);
		return 7 + f[1:0] + f[3];
	endfunction

	// Frame start to next frame start, including the one idle clock.
	function automatic longint exp_period(input logic [7:0] f);
		int stop;
		stop = !f[2] ? 16 : (f[1:0] == 2'h0 ? 24 : 32);
		return longint'(((6 + f[1:0] + f[3]) * 16 + stop + 1) * 100);
	endfunction

	////////////////////////////////////////////////////////////////////////
	task automatic bus_wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		avs_address <= a;
		avs_writedata <= {24'h0, d};
		avs_write <= 1'b1;
		do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
	endtask

	task automatic bus_rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		avs_address <= a;
		avs_read <= 1'b1;
		do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
		d = avs_readdata[7:0];
		avs_read <= 1'b0;
	endtask

	task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
		n_tests++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic chk_word(input logic [63:0] g, input logic [63:0] e);
		n_tests++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic wait_cap(input int n);
		for (int i = 0; i < 3000; i++) begin
			if (usc_line_partner_inst.capq.size() >= n) begin
				break;
			end
			@(posedge clk_sys);
		end
	endtask

	task automatic give_verdict;
		$display("errors %0d comparisons %0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// The whole sequence needs some 10500 cycles; about three times that means a hang.
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 30000) begin
			n_errors++;
			give_verdict();
		end
	end

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		bus_rd(3'h3, q); chk_byte(q, 8'h00);
		bus_rd(3'h4, q); chk_byte(q, 8'h00);
		bus_rd(3'h5, q); chk_byte(q, 8'h60);
		chk_byte(pins, 8'h0e);
		bus_wr(3'h4, 8'he3);
		bus_rd(3'h4, q); chk_byte(q, 8'h03);
		chk_byte(pins, 8'h08);
		bus_wr(3'h4, 8'h0c);
		bus_rd(3'h4, q); chk_byte(q, 8'h0c);
		chk_byte(pins, 8'h0f);
		bus_wr(3'h3, 8'h43);
		repeat (20) @(posedge clk_sys);
		chk_byte(pins, 8'h07);
		bus_wr(3'h3, 8'h03);
		repeat (2) @(posedge clk_sys);
		chk_byte(pins, 8'h0f);
		repeat (200) @(posedge clk_sys);
		usc_line_partner_inst.capq.delete();
		// Divisor access stays clear so index 0 reaches the data path.
		for (int k = 0; k < 8; k++) begin
			r = $random(seed);
			lf = {2'b00, r[5:2], k[1:0]};
			d1 = r[15:8];
			d2 = r[23:16];
			bad = r[24] & lf[3];
			bus_wr(3'h3, lf);
			usc_line_partner_inst.nbits = n_bits(lf);
			bus_wr(3'h0, d1);
			bus_wr(3'h0, d2);
			wait_cap(2);
			chk_word(usc_line_partner_inst.capq[0], mk_frame(d1, lf, 0));
			chk_word(usc_line_partner_inst.capq[1], mk_frame(d2, lf, 0));
			chk_word(usc_line_partner_inst.period, exp_period(lf));
			usc_line_partner_inst.capq.delete();
			// One stop bit only, even when two are configured.
			usc_line_partner_inst.send_char(mk_frame(d1, lf, bad), n_bits(lf));
			bus_rd(3'h5, q); chk_byte(q & 8'h07, {5'h0, bad, 2'b01});
			bus_rd(3'h0, q); chk_byte(q, d1 & (8'hff >> (2'd3 - lf[1:0])));
			bus_rd(3'h5, q); chk_byte(q & 8'h01, 8'h00);
		end
		bus_wr(3'h3, 8'h03);
		bus_wr(3'h1, 8'h04);
		usc_line_partner_inst.nbits = 10;
		repeat (2) usc_line_partner_inst.send_char(mk_frame(8'h5a, 8'h03, 0), 10);
		chk_byte(irq_out, 8'h01);
		bus_rd(3'h5, q); chk_byte(q & 8'h03, 8'h03);
		bus_rd(3'h5, q); chk_byte(q & 8'h02, 8'h00);
		chk_byte(irq_out, 8'h00);
		bus_rd(3'h0, q); chk_byte(q, 8'h5a);
		// Enable is set with each fifo_control write until the 8'h00 write turns it off.
		bus_wr(3'h2, 8'hc9);
		bus_rd(3'h2, q); chk_byte(q & 8'hc0, 8'hc0);
		// Only the receive data interrupt is on, at the 14-byte level.
		bus_wr(3'h1, 8'h01);
		for (int i = 0; i < 17; i++) begin
			usc_line_partner_inst.send_char(mk_frame(8'(i + 1), 8'h03, 0), 10);
			if (i == 12) begin
				chk_byte(irq_out, 8'h00);
			end
			if (i == 13) begin
				chk_byte(irq_out, 8'h01);
			end
		end
		bus_rd(3'h5, q); chk_byte(q & 8'h03, 8'h03);
		bus_rd(3'h0, q); chk_byte(q, 8'h01);
		bus_wr(3'h2, 8'h03);
		bus_rd(3'h5, q); chk_byte(q & 8'h01, 8'h00);
		bus_wr(3'h0, 8'h11);
		bus_wr(3'h0, 8'h22);
		bus_wr(3'h0, 8'h33);
		bus_wr(3'h2, 8'h05);
		bus_rd(3'h5, q); chk_byte(q & 8'h20, 8'h20);
		wait_cap(2);
		chk_word(usc_line_partner_inst.capq.size(), 1);
		chk_word(usc_line_partner_inst.capq[0], mk_frame(8'h11, 8'h03, 0));
		usc_line_partner_inst.send_char(mk_frame(8'h77, 8'h03, 0), 10);
		bus_wr(3'h2, 8'h00);
		bus_rd(3'h5, q); chk_byte(q & 8'h01, 8'h00);
		bus_rd(3'h2, q); chk_byte(q & 8'hc0, 8'h00);
		// Asserted modem inputs must not reach status while looped.
		modem_n <= 4'h0;
		bus_wr(3'h4, 8'h15);
		usc_line_partner_inst.capq.delete();
		bus_wr(3'h0, 8'ha7);
		repeat (250) @(posedge clk_sys);
		chk_byte(pins, 8'h0e);
		bus_rd(3'h6, q); chk_byte(q & 8'hf0, 8'h60);
		chk_byte(irq_out, 8'h01);
		bus_rd(3'h0, q); chk_byte(q, 8'ha7);
		chk_word(usc_line_partner_inst.capq.size(), 0);
		give_verdict();
	end
endmodule
`default_nettype wire
